//--- inc/dlk_pkg.sv
package dlk_pkg;
  // fifo geometry
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int BYTE_W = 8;
  localparam int WORD_BYTES = 4;

  // link type codes sent with every 32-bit link word
  localparam logic [2:0] LT_CMD_HI = 3'h1;
  localparam logic [2:0] LT_CMD_LO = 3'h2;
  localparam logic [2:0] LT_CMD_ONE = 3'h3;
  localparam logic [2:0] LT_RSP_HI = 3'h4;
  localparam logic [2:0] LT_RSP_LO = 3'h5;
  localparam logic [2:0] LT_RSP_ONE = 3'h6;

  // destination io slot inside the 64-bit command data
  localparam int SLOT_MSB = 47;
  localparam int SLOT_LSB = 44;
  localparam logic [3:0] LOCAL_SLOT = 4'hF;
  localparam logic [5:0] CMD_TYPE_READ = 6'h01;
  localparam logic PAR_ODD = 1'b1;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] par;
    logic [2:0] ltype;
    logic [3:0] src;
    logic [3:0] dst;
    logic dpar;
    logic [5:0] typ;
    logic tpar;
  } dlk_word_t;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0] par;
    logic [3:0] src;
    logic [3:0] dst;
    logic dpar;
    logic [5:0] typ;
    logic tpar;
  } dlk_cmd_t;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0] par;
    logic [3:0] src;
    logic [3:0] dst;
    logic [5:0] typ;
    logic tpar;
  } dlk_rsp_t;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0] par;
    logic [3:0] src;
    logic [3:0] arbitration_destination_field;
    logic [3:0] bus_destination_field;
    logic dpar;
    logic [5:0] typ;
    logic tpar;
  } dlk_out_t;
endpackage : dlk_pkg

//--- hdl/dlk_afifo.sv
`timescale 1ns/100ps
module dlk_afifo
  import dlk_pkg::*;
#(
  parameter int W = 8
)
(
  // write side
  input wire logic wclk_i,
  input wire logic wrst_n_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [W-1:0] wdata_i,
  // read side
  input wire logic rclk_i,
  input wire logic rrst_n_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem [FIFO_DEPTH];
  logic [PTR_W:0] wbin, wgray, rbin, rgray;
  logic [PTR_W:0] wg_s1, wg_s2, rg_s1, rg_s2;
  logic [PTR_W:0] next_wbin, next_rbin;

  function automatic logic [PTR_W:0] to_gray(input logic [PTR_W:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  assign next_wbin = wbin + 1'b1;
  assign next_rbin = rbin + 1'b1;
  // full when gray pointers differ only in the two top bits
  assign wready_o = wgray != {~rg_s2[PTR_W:PTR_W-1], rg_s2[PTR_W-2:0]};
  assign rvalid_o = rgray != wg_s2;
  assign rdata_o = mem[rbin[PTR_W-1:0]];

  always_ff @(posedge wclk_i)
  begin
    if (wvalid_i && wready_o)
    begin
      mem[wbin[PTR_W-1:0]] <= wdata_i;
    end
  end

  always_ff @(posedge wclk_i or negedge wrst_n_i)
  begin
    if (!wrst_n_i)
    begin
      wbin <= '0;
      wgray <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
    end
    else
    begin
      rg_s1 <= rgray;
      rg_s2 <= rg_s1;
      if (wvalid_i && wready_o)
      begin
        wbin <= next_wbin;
        wgray <= to_gray(next_wbin);
      end
    end
  end

  always_ff @(posedge rclk_i or negedge rrst_n_i)
  begin
    if (!rrst_n_i)
    begin
      rbin <= '0;
      rgray <= '0;
      wg_s1 <= '0;
      wg_s2 <= '0;
    end
    else
    begin
      wg_s1 <= wgray;
      wg_s2 <= wg_s1;
      if (rready_i && rvalid_o)
      begin
        rbin <= next_rbin;
        rgray <= to_gray(next_rbin);
      end
    end
  end

  a_push_not_full: assert property (@(posedge wclk_i) disable iff (!wrst_n_i)
    wvalid_i |-> wready_o)
    else $error("write into a full fifo");

  a_pop_not_empty: assert property (@(posedge rclk_i) disable iff (!rrst_n_i)
    rready_i |-> rvalid_o)
    else $error("read from an empty fifo");
endmodule : dlk_afifo

//--- hdl/dlk_pulse_sync.sv
`timescale 1ns/100ps
module dlk_pulse_sync
  import dlk_pkg::*;
(
  // source domain
  input wire logic src_clk_i,
  input wire logic src_rst_n_i,
  input wire logic src_pulse_i,
  // destination domain
  input wire logic dst_clk_i,
  input wire logic dst_rst_n_i,
  output logic dst_pulse_o
);
  logic toggle, s1, s2, s3;

  always_ff @(posedge src_clk_i or negedge src_rst_n_i)
  begin
    if (!src_rst_n_i)
    begin
      toggle <= 1'b0;
    end
    else if (src_pulse_i)
    begin
      toggle <= ~toggle;
    end
  end

  always_ff @(posedge dst_clk_i or negedge dst_rst_n_i)
  begin
    if (!dst_rst_n_i)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dst_pulse_o <= 1'b0;
    end
    else
    begin
      s1 <= toggle;
      s2 <= s1;
      s3 <= s2;
      dst_pulse_o <= s2 ^ s3;
    end
  end
endmodule : dlk_pulse_sync

//--- hdl/dlk_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - cross-bus strobe means ours; destination field is a central-bus slot.
// - downward command destination slot comes from data bits 47:44.
// - slot value F in bits 47:44 addresses this module pair.
// - keep source slot of issued reads; use it as returning response destination.
// - check every link word; only clean entries enter the fifos.
// - two 32-bit link words, placed by link type, form one 64-bit entry.
// - single-word responses and reads fill both halves with one word.
// - local register commands bypass the fifo and bump the command counter.
// - separate eight-entry command and response fifos.
// - fifos written on link clock, read on io bus clock.
// - response entry: data, parity, source, destination, type, type parity.
// - command entry: data, parity, source, destination+parity, type+parity.
// - responses go before commands; a waiting command backs off.
// - sent command leaves fifo and pulses ready increment on link clock.
module dlk_top
  import dlk_pkg::*;
(
  // clocks and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic LNK_CLK_I,
  // down-link words, link clock
  input wire logic LNK_VALID_I,
  input dlk_word_t LNK_WORD_I,
  output logic LNK_ERR_O,
  output logic LNK_CMD_INC_O,
  output logic LNK_RDY_INC_O,
  // local register commands, link clock
  output logic LOC_VALID_O,
  output dlk_cmd_t LOC_CMD_O,
  // io system bus output side
  output logic OUT_VALID_O,
  output logic OUT_IS_RSP_O,
  output dlk_out_t OUT_ENTRY_O,
  input wire logic OUT_SENT_I,
  output logic [3:0] UP_RSP_DEST_O,
  // cross-bus commands seen on the io system bus
  input wire logic IO_SYSTEM_BUS_CMD_VALID_I,
  input wire logic IO_SYSTEM_BUS_XBUS_ACTIVE_I,
  input wire logic [3:0] IO_SYSTEM_BUS_BUS_DESTINATION_FIELD_I,
  output logic XBUS_FWD_O,
  output logic [3:0] XBUS_CSS_SLOT_O
);
  logic [1:0] rst_sync, lrst_sync;
  logic rst_n, lrst_n;
  logic in_valid;
  dlk_word_t in_word;
  logic [WORD_BYTES-1:0] byte_bad;
  logic is_hi, is_lo, is_one, is_rsp, lt_bad;
  logic half_pend, hold_rsp;
  logic [31:0] hold_hi;
  logic [3:0] hold_par;
  logic done, local_cmd, word_err;
  logic [63:0] entry64;
  logic [7:0] entry_par;
  logic cmd_push, rsp_push, loc_push;
  logic cmd_wready, rsp_wready, cmd_rvalid, rsp_rvalid, cmd_pop, rsp_pop;
  dlk_cmd_t cmd_wdata, cmd_rdata;
  dlk_rsp_t rsp_wdata, rsp_rdata;
  logic [3:0] cmd_slot, cmd_src;

  // resets released through two flops in each domain
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge LNK_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      lrst_sync <= 2'h0;
    end
    else
    begin
      lrst_sync <= {lrst_sync[0], 1'b1};
    end
  end
  assign lrst_n = lrst_sync[1];

  // link words arrive on the link clock itself; one register stage at the pins
  always_ff @(posedge LNK_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      in_valid <= 1'b0;
      in_word <= '0;
    end
    else
    begin
      in_valid <= LNK_VALID_I;
      in_word <= LNK_WORD_I;
    end
  end

  for (genvar b = 0; b < WORD_BYTES; b++)
  begin : g_par
    assign byte_bad[b] = (^{in_word.data[BYTE_W*b +: BYTE_W], in_word.par[b]}) != PAR_ODD;
  end

  always_comb
  begin
    is_hi = 1'b0;
    is_lo = 1'b0;
    is_one = 1'b0;
    is_rsp = 1'b0;
    lt_bad = 1'b0;
    unique case (in_word.ltype)
      LT_CMD_HI: is_hi = 1'b1;
      LT_CMD_LO: is_lo = 1'b1;
      LT_CMD_ONE: is_one = 1'b1;
      LT_RSP_HI:
      begin
        is_hi = 1'b1;
        is_rsp = 1'b1;
      end
      LT_RSP_LO:
      begin
        is_lo = 1'b1;
        is_rsp = 1'b1;
      end
      LT_RSP_ONE:
      begin
        is_one = 1'b1;
        is_rsp = 1'b1;
      end
      default: lt_bad = 1'b1;
    endcase
  end

  // a single word is copied to both halves
  assign entry64 = is_one ? {in_word.data, in_word.data} : {hold_hi, in_word.data};
  assign entry_par = is_one ? {in_word.par, in_word.par} : {hold_par, in_word.par};
  assign done = in_valid && (is_one || (is_lo && half_pend && (hold_rsp == is_rsp)));
  assign local_cmd = !is_rsp && (entry64[SLOT_MSB:SLOT_LSB] == LOCAL_SLOT);

  always_comb
  begin
    word_err = 1'b0;
    if (in_valid)
    begin
      word_err = (|byte_bad) || lt_bad || ((^{in_word.typ, in_word.tpar}) != PAR_ODD);
      if (!is_rsp && ((^{in_word.dst, in_word.dpar}) != PAR_ODD))
      begin
        word_err = 1'b1;
      end
      // a new first half while one is pending, or a lone second half
      if (((is_hi || is_one) && half_pend) || (is_lo && !done))
      begin
        word_err = 1'b1;
      end
      if (done && (is_rsp ? !rsp_wready : (!local_cmd && !cmd_wready)))
      begin
        word_err = 1'b1;
      end
    end
  end

  assign cmd_push = done && !word_err && !is_rsp && !local_cmd;
  assign rsp_push = done && !word_err && is_rsp;
  assign loc_push = done && !word_err && local_cmd;

  assign cmd_wdata = '{data: entry64, par: entry_par, src: in_word.src, dst: in_word.dst,
                       dpar: in_word.dpar, typ: in_word.typ, tpar: in_word.tpar};
  assign rsp_wdata = '{data: entry64, par: entry_par, src: in_word.src, dst: in_word.dst,
                       typ: in_word.typ, tpar: in_word.tpar};

  // first half held until its partner arrives; any error drops it
  always_ff @(posedge LNK_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      half_pend <= 1'b0;
      hold_rsp <= 1'b0;
      hold_hi <= '0;
      hold_par <= '0;
    end
    else if (in_valid)
    begin
      if (word_err)
      begin
        half_pend <= 1'b0;
      end
      else if (is_hi)
      begin
        half_pend <= 1'b1;
        hold_rsp <= is_rsp;
        hold_hi <= in_word.data;
        hold_par <= in_word.par;
      end
      else
      begin
        half_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge LNK_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      LNK_ERR_O <= 1'b0;
      LNK_CMD_INC_O <= 1'b0;
      LOC_VALID_O <= 1'b0;
      LOC_CMD_O <= '0;
    end
    else
    begin
      LNK_ERR_O <= in_valid && word_err;
      LNK_CMD_INC_O <= loc_push;
      LOC_VALID_O <= loc_push;
      if (loc_push)
      begin
        LOC_CMD_O <= cmd_wdata;
      end
    end
  end

  dlk_afifo #(.W($bits(dlk_cmd_t))) u_cmd_fifo (
    .wclk_i(LNK_CLK_I),
    .wrst_n_i(lrst_n),
    .wvalid_i(cmd_push),
    .wready_o(cmd_wready),
    .wdata_i(cmd_wdata),
    .rclk_i(CLK_I),
    .rrst_n_i(rst_n),
    .rvalid_o(cmd_rvalid),
    .rready_i(cmd_pop),
    .rdata_o(cmd_rdata)
  );

  dlk_afifo #(.W($bits(dlk_rsp_t))) u_rsp_fifo (
    .wclk_i(LNK_CLK_I),
    .wrst_n_i(lrst_n),
    .wvalid_i(rsp_push),
    .wready_o(rsp_wready),
    .wdata_i(rsp_wdata),
    .rclk_i(CLK_I),
    .rrst_n_i(rst_n),
    .rvalid_o(rsp_rvalid),
    .rready_i(rsp_pop),
    .rdata_o(rsp_rdata)
  );

  // output side, io bus clock; selection redone every cycle so a command backs off
  assign OUT_VALID_O = rsp_rvalid || cmd_rvalid;
  assign OUT_IS_RSP_O = rsp_rvalid;
  assign rsp_pop = OUT_SENT_I && rsp_rvalid;
  assign cmd_pop = OUT_SENT_I && !rsp_rvalid && cmd_rvalid;
  assign cmd_slot = cmd_rdata.data[SLOT_MSB:SLOT_LSB];
  assign cmd_src = cmd_rdata.src;

  always_comb
  begin
    if (rsp_rvalid)
    begin
      OUT_ENTRY_O = '{data: rsp_rdata.data, par: rsp_rdata.par, src: rsp_rdata.src,
                      arbitration_destination_field: rsp_rdata.dst, bus_destination_field: rsp_rdata.dst,
                      dpar: PAR_ODD ^ (^rsp_rdata.dst), typ: rsp_rdata.typ,
                      tpar: rsp_rdata.tpar};
    end
    else
    begin
      OUT_ENTRY_O = '{data: cmd_rdata.data, par: cmd_rdata.par, src: cmd_rdata.src,
                      arbitration_destination_field: cmd_slot, bus_destination_field: cmd_slot,
                      dpar: PAR_ODD ^ (^cmd_slot), typ: cmd_rdata.typ,
                      tpar: cmd_rdata.tpar};
    end
  end

  // one read outstanding, so a single register holds its requester
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      UP_RSP_DEST_O <= 4'h0;
    end
    else if (cmd_pop && (cmd_rdata.typ == CMD_TYPE_READ))
    begin
      UP_RSP_DEST_O <= cmd_src;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      XBUS_FWD_O <= 1'b0;
      XBUS_CSS_SLOT_O <= 4'h0;
    end
    else
    begin
      XBUS_FWD_O <= IO_SYSTEM_BUS_CMD_VALID_I && IO_SYSTEM_BUS_XBUS_ACTIVE_I;
      if (IO_SYSTEM_BUS_CMD_VALID_I && IO_SYSTEM_BUS_XBUS_ACTIVE_I)
      begin
        XBUS_CSS_SLOT_O <= IO_SYSTEM_BUS_BUS_DESTINATION_FIELD_I;
      end
    end
  end

  dlk_pulse_sync u_rdy_sync (
    .src_clk_i(CLK_I),
    .src_rst_n_i(rst_n),
    .src_pulse_i(cmd_pop),
    .dst_clk_i(LNK_CLK_I),
    .dst_rst_n_i(lrst_n),
    .dst_pulse_o(LNK_RDY_INC_O)
  );

  sequence s_second_half;
    in_valid && is_lo && half_pend && !word_err;
  endsequence

  a_pair_assembly: assert property (@(posedge LNK_CLK_I) disable iff (!lrst_n)
    s_second_half |-> (cmd_push || rsp_push || loc_push) && (entry64[63:32] == hold_hi))
    else $error("second half did not complete the held entry");

  a_error_discards: assert property (@(posedge LNK_CLK_I) disable iff (!lrst_n)
    (in_valid && word_err) |-> !cmd_push && !rsp_push && !loc_push ##1 !half_pend)
    else $error("errored transfer left data behind");

  a_clean_loaded: assert property (@(posedge LNK_CLK_I) disable iff (!lrst_n)
    (done && !word_err && is_rsp) |-> rsp_push ##1 !LNK_ERR_O)
    else $error("clean response not loaded");

  a_single_both: assert property (@(posedge LNK_CLK_I) disable iff (!lrst_n)
    ((cmd_push || rsp_push) && is_one) |-> (entry64[63:32] == entry64[31:0]))
    else $error("single word not in both halves");

  a_local_stripped: assert property (@(posedge LNK_CLK_I) disable iff (!lrst_n)
    loc_push |-> !cmd_push ##1 (LNK_CMD_INC_O && LOC_VALID_O))
    else $error("local command not stripped");

  a_rdy_single: assert property (@(posedge LNK_CLK_I) disable iff (!lrst_n)
    LNK_RDY_INC_O |=> !LNK_RDY_INC_O)
    else $error("ready increment longer than one cycle");

  a_response_first: assert property (@(posedge CLK_I) disable iff (!rst_n)
    rsp_rvalid |-> OUT_IS_RSP_O && !cmd_pop)
    else $error("command went ahead of a response");

  a_cmd_dest_slot: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (OUT_VALID_O && !OUT_IS_RSP_O) |-> (OUT_ENTRY_O.arbitration_destination_field == cmd_slot)
      && (OUT_ENTRY_O.bus_destination_field == cmd_slot))
    else $error("command destination not from data slot bits");

  a_read_src_kept: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (cmd_pop && (cmd_rdata.typ == CMD_TYPE_READ)) |=> (UP_RSP_DEST_O == $past(cmd_src)))
    else $error("read source slot not kept");

  a_xbus_accept: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (IO_SYSTEM_BUS_CMD_VALID_I && IO_SYSTEM_BUS_XBUS_ACTIVE_I) |=> XBUS_FWD_O
      && (XBUS_CSS_SLOT_O == $past(IO_SYSTEM_BUS_BUS_DESTINATION_FIELD_I)))
    else $error("cross-bus command not taken");
endmodule : dlk_top

//--- verif/dlk_link_model.sv
`timescale 1ns/100ps
module dlk_link_model
  import dlk_pkg::*;
(
  // link side
  input wire logic lnk_clk_i,
  output logic valid_o,
  output dlk_word_t word_o
);
  initial
  begin
    valid_o = 1'b0;
    word_o = '0;
  end

  // every word goes out with its link type and odd parities, except byte 0 parity when bad is set
  task automatic send(input logic [2:0] lt, input logic [31:0] d, input logic [5:0] typ,
                      input logic [3:0] src, input logic [3:0] dst, input logic bad);
    dlk_word_t w;
    w.data = d;
    w.ltype = lt;
    w.src = src;
    w.dst = dst;
    w.dpar = ~^dst;
    w.typ = typ;
    w.tpar = ~^typ;
    for (int b = 0; b < WORD_BYTES; b++)
      w.par[b] = ~^d[8*b +: 8];
    // bad flips one byte parity, for error scenarios only
    w.par[0] = w.par[0] ^ bad;
    @(posedge lnk_clk_i);
    valid_o <= 1'b1;
    word_o <= w;
  endtask : send

  // released lines show the inverse so stale data cannot pass for good
  task automatic idle();
    @(posedge lnk_clk_i);
    valid_o <= 1'b0;
    word_o <= ~word_o;
  endtask : idle
endmodule : dlk_link_model

//--- verif/dlk_top_tb.sv
`timescale 1ns/100ps
module dlk_top_tb
  import dlk_pkg::*;
;
  logic CLK_I, RSTN_I, LNK_CLK_I, LNK_VALID_I, OUT_SENT_I;
  logic IO_SYSTEM_BUS_CMD_VALID_I, IO_SYSTEM_BUS_XBUS_ACTIVE_I;
  logic [3:0] IO_SYSTEM_BUS_BUS_DESTINATION_FIELD_I, UP_RSP_DEST_O, XBUS_CSS_SLOT_O;
  logic LNK_ERR_O, LNK_CMD_INC_O, LNK_RDY_INC_O, LOC_VALID_O;
  logic OUT_VALID_O, OUT_IS_RSP_O, XBUS_FWD_O;
  dlk_word_t LNK_WORD_I;
  dlk_cmd_t LOC_CMD_O;
  dlk_out_t OUT_ENTRY_O;
  int errors = 0;
  int compares = 0;
  int n_err = 0;
  int n_inc = 0;
  int n_rdy = 0;
  int n_loc = 0;
  logic [63:0] loc_data;

  dlk_top u_dlk_top (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .LNK_CLK_I(LNK_CLK_I),
    .LNK_VALID_I(LNK_VALID_I), .LNK_WORD_I(LNK_WORD_I), .LNK_ERR_O(LNK_ERR_O),
    .LNK_CMD_INC_O(LNK_CMD_INC_O), .LNK_RDY_INC_O(LNK_RDY_INC_O),
    .LOC_VALID_O(LOC_VALID_O), .LOC_CMD_O(LOC_CMD_O), .OUT_VALID_O(OUT_VALID_O),
    .OUT_IS_RSP_O(OUT_IS_RSP_O), .OUT_ENTRY_O(OUT_ENTRY_O), .OUT_SENT_I(OUT_SENT_I),
    .UP_RSP_DEST_O(UP_RSP_DEST_O), .IO_SYSTEM_BUS_CMD_VALID_I(IO_SYSTEM_BUS_CMD_VALID_I),
    .IO_SYSTEM_BUS_XBUS_ACTIVE_I(IO_SYSTEM_BUS_XBUS_ACTIVE_I), .IO_SYSTEM_BUS_BUS_DESTINATION_FIELD_I(IO_SYSTEM_BUS_BUS_DESTINATION_FIELD_I),
    .XBUS_FWD_O(XBUS_FWD_O), .XBUS_CSS_SLOT_O(XBUS_CSS_SLOT_O)
  );

  dlk_link_model u_dlk_link_model (
    .lnk_clk_i(LNK_CLK_I), .valid_o(LNK_VALID_I), .word_o(LNK_WORD_I)
  );

  initial
  begin
    CLK_I = 1'b0;
    forever #12.5 CLK_I = ~CLK_I;
  end

  // link clock free running, offset so edges never line up
  initial
  begin
    LNK_CLK_I = 1'b0;
    #1.7;
    forever #3 LNK_CLK_I = ~LNK_CLK_I;
  end

  // one-cycle link pulses are tallied where they stand
  always @(posedge LNK_CLK_I)
  begin
    if (LNK_ERR_O === 1'b1) n_err++;
    if (LNK_CMD_INC_O === 1'b1) n_inc++;
    if (LNK_RDY_INC_O === 1'b1) n_rdy++;
    if (LOC_VALID_O === 1'b1)
    begin
      n_loc++;
      loc_data = LOC_CMD_O.data;
    end
  end

  task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // odd parity per byte, as the link sender forms it
  function automatic logic [7:0] odd_par(input logic [63:0] d);
    logic [7:0] p;
    for (int b = 0; b < 8; b++)
      p[b] = ~^d[8*b +: 8];
    return p;
  endfunction : odd_par

  task automatic finish_test();
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic settle();
    repeat (6) @(negedge CLK_I);
  endtask : settle

  // wait for an offer of the wanted kind, bounded
  task automatic wait_out(input logic rsp);
    int n;
    n = 0;
    while (!(OUT_VALID_O === 1'b1 && OUT_IS_RSP_O === rsp) && n < 60)
    begin
      @(negedge CLK_I);
      n++;
    end
    check("offer kind", {OUT_VALID_O, OUT_IS_RSP_O}, {1'b1, rsp});
  endtask : wait_out

  // sends spaced four io clocks apart
  task automatic pop();
    @(posedge CLK_I);
    OUT_SENT_I <= 1'b1;
    @(posedge CLK_I);
    OUT_SENT_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
  endtask : pop

  task automatic t_cmd_pair();
    u_dlk_link_model.send(LT_CMD_HI, 32'hA5A5_5ABC, 6'h02, 4'h3, 4'h0, 1'b0);
    u_dlk_link_model.send(LT_CMD_LO, 32'h0F1E_2D3C, 6'h02, 4'h3, 4'h0, 1'b0);
    u_dlk_link_model.idle();
    wait_out(1'b0);
    check("cmd data", OUT_ENTRY_O.data, 64'hA5A5_5ABC_0F1E_2D3C);
    check("cmd arb", OUT_ENTRY_O.arbitration_destination_field, 64'h5);
    check("cmd dest", OUT_ENTRY_O.bus_destination_field, 64'h5);
    check("cmd src typ", {OUT_ENTRY_O.src, OUT_ENTRY_O.typ}, {4'h3, 6'h02});
    check("cmd par", {OUT_ENTRY_O.par, OUT_ENTRY_O.dpar, OUT_ENTRY_O.tpar},
          {odd_par(64'hA5A5_5ABC_0F1E_2D3C), 1'b1, 1'b0});
    pop();
    settle();
    check("ready incs", n_rdy, 1);
  endtask : t_cmd_pair

  task automatic t_read_one();
    u_dlk_link_model.send(LT_CMD_ONE, 32'h0000_6001, CMD_TYPE_READ, 4'hA, 4'h0, 1'b0);
    u_dlk_link_model.idle();
    wait_out(1'b0);
    check("read data", OUT_ENTRY_O.data, 64'h0000_6001_0000_6001);
    check("read dest", OUT_ENTRY_O.bus_destination_field, 64'h6);
    pop();
    check("rsp dest slot", UP_RSP_DEST_O, 64'hA);
  endtask : t_read_one

  task automatic t_rsp_first();
    u_dlk_link_model.send(LT_CMD_ONE, 32'h0000_2222, 6'h02, 4'h1, 4'h0, 1'b0);
    // far side response carries destination slot 9, not the kept requester slot A
    u_dlk_link_model.send(LT_RSP_HI, 32'hCAFE_0001, 6'h05, 4'h2, 4'h9, 1'b0);
    u_dlk_link_model.send(LT_RSP_LO, 32'hBEEF_0002, 6'h05, 4'h2, 4'h9, 1'b0);
    u_dlk_link_model.idle();
    wait_out(1'b1);
    check("rsp data", OUT_ENTRY_O.data, 64'hCAFE_0001_BEEF_0002);
    check("rsp dest", {OUT_ENTRY_O.arbitration_destination_field, OUT_ENTRY_O.bus_destination_field}, 64'h99);
    check("rsp typ", OUT_ENTRY_O.typ, 64'h05);
    check("rsp par", {OUT_ENTRY_O.par, OUT_ENTRY_O.tpar},
          {odd_par(64'hCAFE_0001_BEEF_0002), 1'b1});
    pop();
    wait_out(1'b0);
    check("held cmd", OUT_ENTRY_O.bus_destination_field, 64'h2);
    pop();
    settle();
    check("ready incs", n_rdy, 3);
  endtask : t_rsp_first

  task automatic t_local();
    u_dlk_link_model.send(LT_CMD_ONE, 32'h0000_F010, 6'h02, 4'h1, 4'h0, 1'b0);
    u_dlk_link_model.idle();
    settle();
    check("local count", n_loc, 1);
    check("cmd counter", n_inc, 1);
    check("local data", loc_data, 64'h0000_F010_0000_F010);
    check("not offered", OUT_VALID_O, 1'b0);
  endtask : t_local

  task automatic t_errors();
    u_dlk_link_model.send(LT_RSP_LO, 32'h1111_1111, 6'h05, 4'h1, 4'h2, 1'b0);
    u_dlk_link_model.send(LT_CMD_HI, 32'h0000_3000, 6'h02, 4'h1, 4'h0, 1'b1);
    u_dlk_link_model.send(LT_CMD_LO, 32'h2222_2222, 6'h02, 4'h1, 4'h0, 1'b0);
    u_dlk_link_model.send(3'h7, 32'h3333_3333, 6'h02, 4'h1, 4'h0, 1'b0);
    u_dlk_link_model.send(3'h0, 32'h4444_4444, 6'h02, 4'h1, 4'h0, 1'b0);
    u_dlk_link_model.idle();
    settle();
    check("link errors", n_err, 5);
    check("no half entry", OUT_VALID_O, 1'b0);
  endtask : t_errors

  task automatic t_full();
    for (int i = 0; i <= FIFO_DEPTH; i++)
      u_dlk_link_model.send(LT_CMD_ONE, 32'h0000_3000 | i, 6'h02, 4'h1, 4'h0, 1'b0);
    u_dlk_link_model.idle();
    settle();
    check("overflow", n_err, 6);
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      wait_out(1'b0);
      check("fifo order", OUT_ENTRY_O.data[31:0], 64'h3000 | i);
      pop();
    end
    check("drained", OUT_VALID_O, 1'b0);
    settle();
    check("ready incs", n_rdy, 3 + FIFO_DEPTH);
  endtask : t_full

  task automatic t_xbus();
    // bus sender aims at the adapter with the cross-bus strobe
    @(posedge CLK_I);
    IO_SYSTEM_BUS_CMD_VALID_I <= 1'b1;
    IO_SYSTEM_BUS_XBUS_ACTIVE_I <= 1'b1;
    IO_SYSTEM_BUS_BUS_DESTINATION_FIELD_I <= 4'h7;
    @(posedge CLK_I);
    IO_SYSTEM_BUS_XBUS_ACTIVE_I <= 1'b0;
    @(negedge CLK_I);
    check("xbus fwd", {XBUS_FWD_O, XBUS_CSS_SLOT_O}, {1'b1, 4'h7});
    // strobe low, as a command on the local bus carries
    @(posedge CLK_I);
    IO_SYSTEM_BUS_CMD_VALID_I <= 1'b0;
    @(negedge CLK_I);
    check("local cmd ignored", XBUS_FWD_O, 1'b0);
    // first locked read to a slot on this same bus still goes up
    @(posedge CLK_I);
    IO_SYSTEM_BUS_CMD_VALID_I <= 1'b1;
    IO_SYSTEM_BUS_XBUS_ACTIVE_I <= 1'b1;
    IO_SYSTEM_BUS_BUS_DESTINATION_FIELD_I <= 4'h2;
    @(posedge CLK_I);
    IO_SYSTEM_BUS_CMD_VALID_I <= 1'b0;
    IO_SYSTEM_BUS_XBUS_ACTIVE_I <= 1'b0;
    @(negedge CLK_I);
    check("lock read fwd", {XBUS_FWD_O, XBUS_CSS_SLOT_O}, {1'b1, 4'h2});
  endtask : t_xbus

  initial
  begin
    RSTN_I = 1'b0;
    OUT_SENT_I = 1'b0;
    IO_SYSTEM_BUS_CMD_VALID_I = 1'b0;
    IO_SYSTEM_BUS_XBUS_ACTIVE_I = 1'b0;
    IO_SYSTEM_BUS_BUS_DESTINATION_FIELD_I = 4'h0;
    repeat (6) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
    t_cmd_pair();
    t_read_one();
    t_rsp_first();
    t_local();
    t_errors();
    t_full();
    t_xbus();
    finish_test();
  end

  initial
  begin
    repeat (10000) @(posedge CLK_I);
    errors++;
    finish_test();
  end
endmodule : dlk_top_tb
